/* src/iocsm_pkg.sv */
/*
 * iocsm_pkg: shared constants and types of the I/O connection state machine.
 * Assumes one 25 MHz clock; registers sit on a 32-bit APB slave.
 */
package iocsm_pkg;

	// register byte offsets
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h04;
	localparam logic [7:0] REG_EPR    = 8'h08;
	localparam logic [7:0] REG_PSIZE  = 8'h0C;
	localparam logic [7:0] REG_CSIZE  = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_RDATA  = 8'h18;

	// command register fields
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_ATTR_LSB = 8;

	// config register fields
	localparam int CFG_PENDING_BIT = 0;
	localparam int CFG_VALERR_BIT  = 1;
	localparam int CFG_ACTION_LSB  = 2;

	// status register fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_RUN_BIT   = 5;
	localparam int ST_CODE_LSB  = 8;
	localparam int ST_VALID_BIT = 16;

	// reset values
	localparam logic [15:0] EPR_RESET   = 16'h0000;
	localparam logic [15:0] PSIZE_RESET = 16'h0008;
	localparam logic [15:0] CSIZE_RESET = 16'h0008;

	// general error codes
	localparam logic [7:0] GEN_SUCCESS     = 8'h00;
	localparam logic [7:0] GEN_BAD_VALUE   = 8'h09;
	localparam logic [7:0] GEN_WRONG_STATE = 8'h0C;
	localparam logic [7:0] GEN_NO_ATTR     = 8'h14;
	localparam logic [7:0] GEN_NO_OBJECT   = 8'h16;

	// payload bytes carried by one transmitted fragment
	localparam logic [15:0] FRAG_BYTES = 16'h0007;

	// watchdog tick: the packet rate counts in milliseconds
	localparam int TICK_TIME_NS  = 1000000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		CMD_NONE   = 3'h0,
		CMD_CREATE = 3'h1,
		CMD_DELETE = 3'h2,
		CMD_GET    = 3'h3,
		CMD_RESET  = 3'h4,
		CMD_APPLY  = 3'h5
	} iocsm_cmd_e;

	typedef enum logic [4:0] {
		ST_NONEXIST = 5'h01,
		ST_CONFIG   = 5'h02,
		ST_WAIT     = 5'h04,
		ST_ESTAB    = 5'h08,
		ST_TIMEOUT  = 5'h10
	} iocsm_state_e;

	typedef enum logic [1:0] {
		ACT_TIMEOUT    = 2'h0,
		ACT_DELETE     = 2'h1,
		ACT_AUTORESET  = 2'h2,
		ACT_DEFERRED   = 2'h3
	} iocsm_action_e;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic [15:0] len;
	} iocsm_rx_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] len;
	} iocsm_msg_s;

	typedef struct packed {
		logic        valid;
		logic        first;
		logic        last;
		logic [15:0] len;
	} iocsm_frag_s;

endpackage

/* src/iocsm_watchdog.sv */
/*
 * iocsm_watchdog: inactivity timer counting in millisecond ticks.
 * Assumes a load and a stop never arrive together; load wins if they do.
 */
module iocsm_watchdog
	import iocsm_pkg::*;
#(
	parameter int TICKS = TICK_CYCLES
) (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	// control
	input  wire logic        i_load,
	input  wire logic [15:0] i_value,
	input  wire logic        i_stop,
	// status
	output logic             o_running,
	output logic             o_expire
);

	logic [31:0] div_q;
	logic [15:0] count_q;
	logic        tick;

	// divider restarts on load so the first period is whole
	assign tick = (div_q == 32'(TICKS - 1));

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			div_q <= 32'h0000_0000;
		end else if (i_load || tick || !o_running) begin
			div_q <= 32'h0000_0000;
		end else begin
			div_q <= div_q + 32'h0000_0001;
		end
	end

	// a zero value leaves the timer stopped
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			count_q   <= 16'h0000;
			o_running <= 1'b0;
			o_expire  <= 1'b0;
		end else begin
			o_expire <= 1'b0;
			if (i_load) begin
				count_q   <= i_value;
				o_running <= (i_value != 16'h0000);
			end else if (i_stop) begin
				o_running <= 1'b0;
			end else if (o_running && tick) begin
				if (count_q == 16'h0001) begin
					o_running <= 1'b0;
					o_expire  <= 1'b1;
				end
				count_q <= count_q - 16'h0001;
			end
		end
	end

endmodule // iocsm_watchdog

/* src/iocsm_top.sv */
/*
 * iocsm_top: one I/O connection with its state machine, register access,
 * receive gating, transmit fragmentation and inactivity watchdog.
 * Assumes APB master on the same clock and synchronous message inputs.
 */
// Behaviour
// - non-existent: get, reset and apply answer error 16h
// - other states: get returns the selected attribute value
// - reset in configuring or waiting answers error 0Ch
// - reset in established restarts watchdog from packet rate
// - reset in timed-out starts watchdog if rate nonzero, back to established
// - apply in configuring with identifier pending: success, go waiting
// - apply in configuring fully configured: start timers, go established
// - apply in configuring with validation error: error, stay configuring
// - apply while waiting and identifier still pending: success, stay waiting
// - apply while waiting with identifiers configured: success, go established
// - apply in established answers 0Ch; settings act at once
// - rx discarded unless established; good message restarts watchdog, delivered
// - send outside established: nothing sent, internal error pulse
// - send in established: split into fragments when above size
// - watchdog expiry in established performs the timeout action
// - received message above consumed size is dropped entirely
// - watchdog not restarted until the last fragment arrives
module iocsm_top
	import iocsm_pkg::*;
#(
	parameter int TICKS = TICK_CYCLES
) (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// network side
	input  wire iocsm_rx_s   i_rx,
	output iocsm_frag_s      o_tx,
	// application side
	input  wire iocsm_msg_s  i_send,
	output iocsm_msg_s       o_deliver,
	output logic             o_send_error,
	output logic             o_tx_busy,
	output logic [4:0]       o_state
);

	iocsm_state_e state_q;
	iocsm_state_e state_d;
	logic [7:0]   code_q;
	logic [7:0]   code_d;
	logic [15:0]  rdata_q;
	logic [15:0]  rdata_d;
	logic         valid_q;
	logic [15:0]  cmd_q;
	logic         pending_q;
	logic         valerr_q;
	logic [1:0]   action_q;
	logic [15:0]  epr_q;
	logic [15:0]  psize_q;
	logic [15:0]  csize_q;
	logic         wd_load;
	logic         wd_stop;
	logic         wd_running;
	logic         wd_expire;
	logic         wr_fire;
	logic         cmd_fire;
	logic         rx_good;
	logic [15:0]  rx_acc_q;
	logic [16:0]  rx_sum;
	logic [15:0]  tx_rem_q;
	logic         tx_split_q;
	logic         tx_first_q;
	logic [15:0]  tx_len;

	// write and command take effect only at the completing edge
	assign wr_fire  = i_psel && i_penable && o_pready && i_pwrite;
	assign cmd_fire = wr_fire && (i_paddr == REG_CMD);

	// no wait state: pready and read data both come from flops
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			o_pready  <= i_psel && !i_penable;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			if (i_psel && !i_penable) begin
				case (i_paddr)
					REG_CMD:    o_prdata <= {16'h0000, cmd_q};
					REG_CONFIG: o_prdata <= {28'h0000000, action_q, valerr_q, pending_q};
					REG_EPR:    o_prdata <= {16'h0000, epr_q};
					REG_PSIZE:  o_prdata <= {16'h0000, psize_q};
					REG_CSIZE:  o_prdata <= {16'h0000, csize_q};
					REG_STATUS: o_prdata <= {15'h0000, valid_q, code_q, 2'h0, wd_running, 5'(state_q)};
					REG_RDATA:  o_prdata <= {16'h0000, rdata_q};
					default:    o_pslverr <= 1'b1;
				endcase
			end
		end
	end

	// software settings; in established they act at once
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			cmd_q     <= 16'h0000;
			pending_q <= 1'b0;
			valerr_q  <= 1'b0;
			action_q  <= 2'h0;
			epr_q     <= EPR_RESET;
			psize_q   <= PSIZE_RESET;
			csize_q   <= CSIZE_RESET;
		end else if (wr_fire) begin
			case (i_paddr)
				REG_CMD: cmd_q <= i_pwdata[15:0];
				REG_CONFIG: begin
					pending_q <= i_pwdata[CFG_PENDING_BIT];
					valerr_q  <= i_pwdata[CFG_VALERR_BIT];
					action_q  <= i_pwdata[CFG_ACTION_LSB +: 2];
				end
				REG_EPR:   epr_q   <= i_pwdata[15:0];
				REG_PSIZE: psize_q <= i_pwdata[15:0];
				REG_CSIZE: csize_q <= i_pwdata[15:0];
				default: ;
			endcase
		end
	end

	// expiry is applied first so a command in the same cycle sees its result
	always_comb begin
		iocsm_cmd_e cmd;
		cmd     = iocsm_cmd_e'(i_pwdata[CMD_CODE_LSB +: 3]);
		state_d = state_q;
		code_d  = code_q;
		rdata_d = rdata_q;
		wd_load = 1'b0;
		wd_stop = 1'b0;
		if (wd_expire && state_q == ST_ESTAB) begin
			case (iocsm_action_e'(action_q))
				ACT_DELETE:    state_d = ST_NONEXIST;
				ACT_AUTORESET: wd_load = 1'b1;
				default:       state_d = ST_TIMEOUT;
			endcase
		end
		if (cmd_fire) begin
			code_d = GEN_SUCCESS;
			case (cmd)
				CMD_CREATE: begin
					if (state_d == ST_NONEXIST) begin
						state_d = ST_CONFIG;
					end else begin
						code_d = GEN_WRONG_STATE;
					end
				end
				CMD_DELETE: begin
					if (state_d == ST_NONEXIST) begin
						code_d = GEN_NO_OBJECT;
					end else begin
						state_d = ST_NONEXIST;
						wd_stop = 1'b1;
						wd_load = 1'b0;
					end
				end
				CMD_GET: begin
					if (state_d == ST_NONEXIST) begin
						code_d = GEN_NO_OBJECT;
					end else begin
						case (i_pwdata[CMD_ATTR_LSB +: 8])
							8'h00:   rdata_d = {11'h000, 5'(state_d)};
							8'h01:   rdata_d = epr_q;
							8'h02:   rdata_d = psize_q;
							8'h03:   rdata_d = csize_q;
							8'h04:   rdata_d = {14'h0000, action_q};
							default: code_d = GEN_NO_ATTR;
						endcase
					end
				end
				CMD_RESET: begin
					case (state_d)
						ST_NONEXIST: code_d = GEN_NO_OBJECT;
						ST_ESTAB: wd_load = 1'b1;
						ST_TIMEOUT: begin
							wd_load = 1'b1;
							state_d = ST_ESTAB;
						end
						default: code_d = GEN_WRONG_STATE;
					endcase
				end
				CMD_APPLY: begin
					case (state_d)
						ST_NONEXIST: code_d = GEN_NO_OBJECT;
						ST_CONFIG: begin
							if (valerr_q) begin
								code_d = GEN_BAD_VALUE;
							end else if (pending_q) begin
								state_d = ST_WAIT;
							end else begin
								state_d = ST_ESTAB;
								wd_load = 1'b1;
							end
						end
						ST_WAIT: begin
							if (!pending_q) begin
								state_d = ST_ESTAB;
								wd_load = 1'b1;
							end
						end
						default: code_d = GEN_WRONG_STATE;
					endcase
				end
				default: code_d = GEN_NO_ATTR;
			endcase
		end
		if (rx_good && state_d == ST_ESTAB) begin
			wd_load = 1'b1;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_q <= ST_NONEXIST;
			code_q  <= GEN_SUCCESS;
			rdata_q <= 16'h0000;
			valid_q <= 1'b0;
			o_state <= 5'(ST_NONEXIST);
		end else begin
			state_q <= state_d;
			code_q  <= code_d;
			rdata_q <= rdata_d;
			valid_q <= valid_q || cmd_fire;
			o_state <= 5'(state_d);
		end
	end

	iocsm_watchdog #(
		.TICKS (TICKS)
	) u_watchdog (
		.i_clock   (i_clock),
		.i_reset   (i_reset),
		.i_load    (wd_load),
		.i_value   (epr_q),
		.i_stop    (wd_stop),
		.o_running (wd_running),
		.o_expire  (wd_expire)
	);

	// length adds up over fragments; only the last one counts
	assign rx_sum = {1'b0, rx_acc_q} + {1'b0, i_rx.len};
	assign rx_good = i_rx.valid && i_rx.last && (state_q == ST_ESTAB) && (rx_sum <= {1'b0, csize_q});

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			rx_acc_q  <= 16'h0000;
			o_deliver <= '0;
		end else begin
			o_deliver.valid <= 1'b0;
			if (i_rx.valid) begin
				rx_acc_q <= i_rx.last ? 16'h0000 : (rx_sum[16] ? 16'hFFFF : rx_sum[15:0]);
				if (rx_good) begin
					o_deliver.valid <= 1'b1;
					o_deliver.len   <= rx_sum[15:0];
				end
			end
		end
	end

	// a send while busy is ignored; software must wait for busy to drop
	assign tx_len = (tx_split_q && tx_rem_q > FRAG_BYTES) ? FRAG_BYTES : tx_rem_q;

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_tx         <= '0;
			o_tx_busy    <= 1'b0;
			o_send_error <= 1'b0;
			tx_rem_q     <= 16'h0000;
			tx_split_q   <= 1'b0;
			tx_first_q   <= 1'b0;
		end else begin
			o_tx.valid   <= 1'b0;
			o_send_error <= 1'b0;
			if (state_q != ST_ESTAB) begin
				o_tx_busy <= 1'b0;
				if (i_send.valid) begin
					o_send_error <= 1'b1;
				end
			end else if (o_tx_busy) begin
				o_tx.valid <= 1'b1;
				o_tx.first <= tx_first_q;
				o_tx.last  <= (tx_rem_q == tx_len);
				o_tx.len   <= tx_len;
				tx_first_q <= 1'b0;
				tx_rem_q   <= tx_rem_q - tx_len;
				o_tx_busy  <= (tx_rem_q != tx_len);
			end else if (i_send.valid) begin
				tx_rem_q   <= i_send.len;
				tx_split_q <= (i_send.len > psize_q);
				tx_first_q <= 1'b1;
				o_tx_busy  <= 1'b1;
			end
		end
	end

endmodule // iocsm_top

/* verif/iocsm_chk.sv */
/*
 * iocsm_chk: port-level assertions for iocsm_top.
 * Assumes it is bound into iocsm_top and sees only its ports.
 */
module iocsm_chk
	import iocsm_pkg::*;
(
	// clock and reset
	input wire logic        i_clock,
	input wire logic        i_reset,
	// apb
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	// messages
	input wire iocsm_rx_s   i_rx,
	input wire iocsm_frag_s o_tx,
	input wire iocsm_msg_s  i_send,
	input wire iocsm_msg_s  o_deliver,
	input wire logic        o_send_error,
	input wire logic        o_tx_busy,
	input wire logic [4:0]  o_state
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (i_reset);

	property p_ready;
		i_psel && !i_penable |=> o_pready ##1 !o_pready;
	endproperty
	a_ready: assert property (p_ready) else $error("apb ready not a single cycle");

	property p_slverr;
		o_pslverr |-> o_pready;
	endproperty
	a_slverr: assert property (p_slverr) else $error("slave error without ready");

	property p_leave_none;
		$changed(o_state) && $past(o_state) == ST_NONEXIST |-> o_state == ST_CONFIG;
	endproperty
	a_leave_none: assert property (p_leave_none) else $error("bad exit from non-existent");

	property p_deliver;
		o_deliver.valid |-> $past(o_state) == ST_ESTAB && $past(i_rx.valid && i_rx.last);
	endproperty
	a_deliver: assert property (p_deliver) else $error("delivery outside established");

	property p_send_err;
		i_send.valid && o_state != ST_ESTAB |=> o_send_error && !o_tx_busy;
	endproperty
	a_send_err: assert property (p_send_err) else $error("send outside established not refused");

	property p_send_ok;
		i_send.valid && o_state == ST_ESTAB && !o_tx_busy |=> !o_send_error && o_tx_busy ##1 o_tx.valid && o_tx.first;
	endproperty
	a_send_ok: assert property (p_send_ok) else $error("send in established not started");

	property p_frag;
		o_tx.valid && !o_tx.last |-> o_tx.len == FRAG_BYTES ##1 o_tx.valid && !o_tx.first;
	endproperty
	a_frag: assert property (p_frag) else $error("bad fragment length or gap");

	property p_tx_gate;
		o_tx.valid |-> $past(o_tx_busy) && $past(o_state) == ST_ESTAB;
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("fragment outside established");

	property p_timeout;
		$changed(o_state) && o_state == ST_TIMEOUT |-> $past(o_state) == ST_ESTAB;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timed-out entered from wrong state");
endmodule // iocsm_chk

bind iocsm_top iocsm_chk u_chk (
	.i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .i_rx(i_rx), .o_tx(o_tx), .i_send(i_send),
	.o_deliver(o_deliver), .o_send_error(o_send_error), .o_tx_busy(o_tx_busy), .o_state(o_state)
);

/* verif/iocsm_peer.sv */
/*
 * iocsm_peer: remote node sending fragmented messages and logging fragments.
 * Assumes its tasks are entered just after a rising clock edge.
 */
module iocsm_peer
	import iocsm_pkg::*;
(
	// clock
	input  wire logic        i_clock,
	// link
	output iocsm_rx_s        o_rx,
	input  wire iocsm_frag_s i_tx
);
	timeunit 1ns;
	timeprecision 1ps;
	iocsm_frag_s frags[$];

	initial o_rx = '{1'b0, 1'b1, 16'hFFFF};

	always @(posedge i_clock) begin
		if (i_tx.valid === 1'b1)
			frags.push_back(i_tx);
	end

	// idle length is inverted so a stale value never looks valid
	task automatic msg(input int n, input logic [15:0] fl);
		for (int i = 0; i < n; i++) begin
			o_rx <= '{1'b1, i == n - 1, fl};
			@(posedge i_clock);
		end
		o_rx <= '{1'b0, 1'b0, ~fl};
	endtask
endmodule // iocsm_peer

/* verif/tb.sv */
/*
 * tb: scenario bench for iocsm_top, peer model on the network side.
 * Assumes 25 MHz clock and a watchdog tick shortened to 4 cycles.
 */
`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("wrong value %s exp %0h got %0h", nm, e, g); \
	end \
end

module tb
	import iocsm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, serr, busy;
	iocsm_rx_s   rx;
	iocsm_frag_s tx;
	iocsm_msg_s  send = '0;
	iocsm_msg_s  deliver;
	logic [4:0]  state;
	logic [15:0] dlv_len;
	int          err_total = 0;
	int          n_checks = 0;
	int          n_dlv = 0;

	iocsm_top #(.TICKS(TK)) u_dut (
		.i_clock(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_rx(rx), .o_tx(tx), .i_send(send), .o_deliver(deliver), .o_send_error(serr),
		.o_tx_busy(busy), .o_state(state)
	);
	iocsm_peer u_peer (.i_clock(clk), .o_rx(rx), .i_tx(tx));

	always #20 clk = ~clk;

	always @(posedge clk) begin
		if (deliver.valid === 1'b1) begin
			n_dlv++;
			dlv_len = deliver.len;
		end
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask

	task automatic stc(input logic [4:0] es);
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK("state", es, rd[4:0])
	endtask

	task automatic cmd(input logic [2:0] c, input logic [7:0] at, input logic [7:0] ec, input logic [4:0] es);
		apb(1'b1, REG_CMD, {16'h0, at, 5'h0, c});
		stc(es);
		`CHK("code", ec, rd[15:8])
		`CHK("done", 1'b1, rd[ST_VALID_BIT])
	endtask

	// fragment count and sizes follow from the produced size and fragment payload
	task automatic sndc(input logic [15:0] ln, input logic ee);
		int n;
		u_peer.frags.delete();
		send <= '{1'b1, ln};
		@(posedge clk);
		send <= '0;
		@(posedge clk);
		`CHK("send_error", ee, serr)
		`CHK("busy", !ee, busy)
		repeat (12) @(posedge clk);
		n = ee ? 0 : (ln > PSIZE_RESET ? (ln + 6) / 7 : 1);
		`CHK("frags", n, u_peer.frags.size())
		for (int i = 0; i < n; i++)
			`CHK("frag", {i == 0, i == n - 1, i < n - 1 ? FRAG_BYTES : ln - FRAG_BYTES * 16'(n - 1)}, u_peer.frags[i][17:0])
	endtask

	task automatic rxc(input int n, input logic [15:0] fl, input logic ed);
		int d0;
		d0 = n_dlv;
		u_peer.msg(n, fl);
		repeat (3) @(posedge clk);
		`CHK("delivered", d0 + int'(ed), n_dlv)
		if (ed) `CHK("dlv_len", fl * 16'(n), dlv_len)
	endtask

	task automatic t_none();
		rdc("psize", REG_PSIZE, {16'h0, PSIZE_RESET});
		rdc("csize", REG_CSIZE, {16'h0, CSIZE_RESET});
		rdc("rate", REG_EPR, {16'h0, EPR_RESET});
		rdc("unmapped", 8'h40, 32'h0);
		`CHK("slverr", 1'b1, er)
		for (int c = 3; c <= 5; c++)
			cmd(3'(c), 8'h0, GEN_NO_OBJECT, ST_NONEXIST);
	endtask

	task automatic t_config();
		cmd(CMD_CREATE, 8'h0, GEN_SUCCESS, ST_CONFIG);
		cmd(CMD_RESET, 8'h0, GEN_WRONG_STATE, ST_CONFIG);
		cmd(CMD_GET, 8'h2, GEN_SUCCESS, ST_CONFIG);
		rdc("attr", REG_RDATA, {16'h0, PSIZE_RESET});
		sndc(16'h4, 1'b1);
		rxc(1, 16'h4, 1'b0);
		apb(1'b1, REG_CONFIG, 32'h2);
		cmd(CMD_APPLY, 8'h0, GEN_BAD_VALUE, ST_CONFIG);
	endtask

	task automatic t_wait();
		apb(1'b1, REG_CONFIG, 32'h1);
		cmd(CMD_APPLY, 8'h0, GEN_SUCCESS, ST_WAIT);
		cmd(CMD_RESET, 8'h0, GEN_WRONG_STATE, ST_WAIT);
		sndc(16'h4, 1'b1);
		cmd(CMD_APPLY, 8'h0, GEN_SUCCESS, ST_WAIT);
		apb(1'b1, REG_CONFIG, 32'h0);
		cmd(CMD_APPLY, 8'h0, GEN_SUCCESS, ST_ESTAB);
		cmd(CMD_APPLY, 8'h0, GEN_WRONG_STATE, ST_ESTAB);
	endtask

	task automatic t_traffic();
		cmd(CMD_GET, 8'h3, GEN_SUCCESS, ST_ESTAB);
		rdc("attr", REG_RDATA, {16'h0, CSIZE_RESET});
		sndc(16'h8, 1'b0);
		sndc(16'hA, 1'b0);
		sndc(16'hF, 1'b0);
		rxc(2, 16'h4, 1'b1);
		rxc(3, 16'h3, 1'b0);
	endtask

	// watchdog: 3 ms at 4 cycles a tick gives 12 cycles
	task automatic t_watchdog();
		apb(1'b1, REG_EPR, 32'h3);
		cmd(CMD_RESET, 8'h0, GEN_SUCCESS, ST_ESTAB);
		`CHK("running", 1'b1, rd[ST_RUN_BIT])
		u_peer.msg(16, 16'h0);
		stc(ST_TIMEOUT);
		sndc(16'h4, 1'b1);
		cmd(CMD_APPLY, 8'h0, GEN_WRONG_STATE, ST_TIMEOUT);
		rxc(1, 16'h2, 1'b0);
		cmd(CMD_RESET, 8'h0, GEN_SUCCESS, ST_ESTAB);
		`CHK("running", 1'b1, rd[ST_RUN_BIT])
		repeat (4) rxc(1, 16'h2, 1'b1);
		stc(ST_ESTAB);
		repeat (16) @(posedge clk);
		stc(ST_TIMEOUT);
		apb(1'b1, REG_CONFIG, 32'h4);
		cmd(CMD_RESET, 8'h0, GEN_SUCCESS, ST_ESTAB);
		repeat (16) @(posedge clk);
		stc(ST_NONEXIST);
		cmd(CMD_DELETE, 8'h0, GEN_NO_OBJECT, ST_NONEXIST);
		// auto-reset action, fully configured apply
		apb(1'b1, REG_CONFIG, 32'h8);
		cmd(CMD_CREATE, 8'h0, GEN_SUCCESS, ST_CONFIG);
		cmd(CMD_APPLY, 8'h0, GEN_SUCCESS, ST_ESTAB);
		`CHK("running", 1'b1, rd[ST_RUN_BIT])
		repeat (16) @(posedge clk);
		stc(ST_ESTAB);
		`CHK("running", 1'b1, rd[ST_RUN_BIT])
		cmd(CMD_DELETE, 8'h0, GEN_SUCCESS, ST_NONEXIST);
		`CHK("running", 1'b0, rd[ST_RUN_BIT])
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_none();
		t_config();
		t_wait();
		t_traffic();
		t_watchdog();
		summarize();
	end

	// whole run is well under 1000 cycles
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		summarize();
	end
endmodule // tb
